// *** bench/cpu_opcode_decode_timing_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

// Timing and decode relations seen at the decoder's ports.
module cpu_opcode_decode_timing_asserts (
   // Clock and reset.
   input wire logic mclk,
   input wire logic nrst,
   // Fetch side.
   input wire logic fetchValid,
   input wire logic fetchReady,
   input wire logic [7:0] fetchByte,
   input wire logic [7:0] operandByte,
   // Core state.
   input wire logic [7:0] accIn,
   input wire logic flagMask,
   input wire logic irqPin,
   // Decoded outputs.
   input wire logic decValid_q,
   input wire logic [2:0] opMode_q,
   input wire logic [1:0] instrLength_q,
   input wire logic [2:0] instrCycles_q,
   input wire logic isRegMem_q,
   input wire logic branchTaken_q,
   input wire logic pushReturn_q,
   input wire logic accWrite_q,
   input wire logic [7:0] accResult_q
);
   // One domain, so clock and reset are given once.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_take_answer:
   assert property (fetchValid && fetchReady |=> decValid_q) else $error("no decode after a take");
   a_answer_cause:
   assert property (decValid_q |-> $past(fetchValid) && $past(fetchReady)) else $error("decode without a take");
   a_three_busy:
   assert property (decValid_q && instrCycles_q == 3'h3 |-> !fetchReady [*2] ##1 fetchReady)
      else $error("3-cycle span wrong");
   a_five_busy:
   assert property (decValid_q && instrCycles_q == 3'h5 |-> !fetchReady [*4] ##1 fetchReady)
      else $error("5-cycle span wrong");
   a_seven_busy:
   assert property (decValid_q && instrCycles_q == 3'h7 |-> !fetchReady [*6] ##1 fetchReady)
      else $error("7-cycle span wrong");
   a_length_mode:
   assert property (decValid_q && isRegMem_q |-> instrLength_q == ((opMode_q == 3'h3) ? 2'h1 :
      (opMode_q == 3'h2 || opMode_q == 3'h5) ? 2'h3 : 2'h2)) else $error("length does not fit mode");
   a_branch_shape:
   assert property (decValid_q && $past(fetchByte[7:4]) == 4'h2 |-> opMode_q == 3'h6 && instrLength_q == 2'h2
      && instrCycles_q == 3'h3) else $error("branch shape wrong");
   a_irq_branch:
   assert property (decValid_q && $past(fetchByte[7:1]) == 7'h17 |-> branchTaken_q == ($past(irqPin) ==
      $past(fetchByte[0]))) else $error("pin branch wrong");
   a_mask_branch:
   assert property (decValid_q && $past(fetchByte[7:1]) == 7'h16 |-> branchTaken_q == ($past(flagMask) ==
      $past(fetchByte[0]))) else $error("mask branch wrong");
   a_call_relative:
   assert property (decValid_q && $past(fetchByte) == 8'had |-> pushReturn_q && instrCycles_q == 3'h6
      && instrLength_q == 2'h2) else $error("relative call wrong");
   a_xor_result:
   assert property (decValid_q && isRegMem_q && $past(fetchByte[3:0]) == 4'h8 |-> accWrite_q &&
      accResult_q == ($past(accIn) ^ $past(operandByte))) else $error("xor result wrong");
   a_write_pulse:
   assert property (accWrite_q |-> decValid_q) else $error("write-back outside a decode");
endmodule

bind cpu_opcode_decode_timing cpu_opcode_decode_timing_asserts checker_inst (.mclk(mclk), .nrst(nrst),
   .fetchValid(fetchValid), .fetchReady(fetchReady), .fetchByte(fetchByte), .operandByte(operandByte),
   .accIn(accIn), .flagMask(flagMask), .irqPin(irqPin), .decValid_q(decValid_q), .opMode_q(opMode_q),
   .instrLength_q(instrLength_q), .instrCycles_q(instrCycles_q), .isRegMem_q(isRegMem_q),
   .branchTaken_q(branchTaken_q), .pushReturn_q(pushReturn_q), .accWrite_q(accWrite_q),
   .accResult_q(accResult_q));

`default_nettype wire

// *** bench/cpu_opcode_decode_timing_test.sv ***
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the opcode decoder.
module cpu_opcode_decode_timing_test;
   logic mclk, nrst, fetchValid, fetchReady, flagCarry, flagZero, flagNegative, flagHalf, flagMask, irqPin;
   logic [7:0] fetchByte, operandByte, accIn, accResult_q;
   logic decValid_q, isRegMem_q, isBranch_q, branchTaken_q, pushReturn_q, illegalOp_q, accWrite_q;
   logic [2:0] opMode_q, instrCycles_q;
   logic [3:0] aluOp_q;
   logic [1:0] instrLength_q;
   int fails = 0;
   int checks = 0;

   cpu_opcode_decode_timing dut (.mclk(mclk), .nrst(nrst), .fetchValid(fetchValid), .fetchByte(fetchByte),
      .operandByte(operandByte), .fetchReady(fetchReady), .accIn(accIn), .flagCarry(flagCarry),
      .flagZero(flagZero), .flagNegative(flagNegative), .flagHalf(flagHalf), .flagMask(flagMask),
      .irqPin(irqPin), .decValid_q(decValid_q), .opMode_q(opMode_q), .aluOp_q(aluOp_q),
      .instrLength_q(instrLength_q), .instrCycles_q(instrCycles_q), .isRegMem_q(isRegMem_q),
      .isBranch_q(isBranch_q), .branchTaken_q(branchTaken_q), .pushReturn_q(pushReturn_q),
      .illegalOp_q(illegalOp_q), .accWrite_q(accWrite_q), .accResult_q(accResult_q));

   prog_memory_model mem (.mclk(mclk), .nrst(nrst), .fetchReady(fetchReady), .fetchValid(fetchValid),
      .fetchByte(fetchByte), .operandByte(operandByte));

   // 40 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Compare one byte of results.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Print the verdict and stop.
   task automatic end_sim();
      if (fails == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Offer one opcode and wait, bounded, for its decode.
   task automatic issue(input logic [7:0] op, input logic [7:0] opd);
      int n;
      mem.put(op, opd);
      n = 0;
      do begin
         @(posedge mclk);
         #2;
         n++;
      end while (decValid_q !== 1'b1 && n < 20);
      chk({7'h0, decValid_q}, 8'h01);
   endtask

   // Every opcode with upper nibble A to F: mode, size, timing and write-back.
   task automatic regmem_sweep();
      logic [2:0] modeTab [6];
      logic [1:0] lenTab [6];
      logic [2:0] cycTab [6];
      logic [7:0] op, res;
      logic [2:0] cyc;
      logic ill, wr;
      modeTab = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h4, 3'h3};
      lenTab = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
      cycTab = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h4, 3'h3};
      accIn = 8'h5c;
      for (int h = 0; h < 6; h++) begin
         for (int l = 0; l < 16; l++) begin
            op = 8'ha0 + 8'(h * 16 + l);
            cyc = cycTab[h] + 3'(l == 7 || l == 15) - 3'(l == 12) + 3'(2 * (l == 13));
            ill = h == 0 && (l == 7 || l == 12 || l == 15);
            wr = l == 4 || l == 6 || l == 8 || l == 10;
            res = l == 4 ? (accIn & 8'h3a) : l == 6 ? 8'h3a : l == 8 ? (accIn ^ 8'h3a) : (accIn | 8'h3a);
            issue(op, 8'h3a);
            if (ill) begin
               chk({1'b0, illegalOp_q, isRegMem_q, instrLength_q, instrCycles_q}, 8'h49);
            end else if (op == 8'had) begin
               chk({1'b0, opMode_q, instrLength_q, branchTaken_q, pushReturn_q}, 8'h6b);
               chk({5'h0, instrCycles_q}, 8'h06);
            end else begin
               chk({opMode_q, instrLength_q, cyc}, {modeTab[h], lenTab[h], cyc});
               chk({5'h0, instrCycles_q}, {5'h0, cyc});
               chk({2'h0, illegalOp_q, isRegMem_q, aluOp_q}, {4'h1, 4'(l)});
               chk({6'h0, pushReturn_q, branchTaken_q}, {6'h0, l == 13, 1'b0});
               chk({7'h0, accWrite_q}, {7'h0, wr});
               if (wr) chk(accResult_q, res);
            end
         end
      end
   endtask

   // Every branch opcode under all 64 flag and pin combinations.
   task automatic branch_sweep();
      logic [5:0] f;
      logic [7:0] b;
      logic t;
      for (int l = 0; l < 16; l++) begin
         for (int k = 0; k < 64; k++) begin
            f = 6'(k);
            // Bit order follows the condition codes: 28/29 half carry, 2A/2B sign.
            {irqPin, flagMask, flagNegative, flagHalf, flagZero, flagCarry} = f;
            b = {f[5:0], f[0] | f[1], 1'b0};
            t = b[l >> 1] ^ ~l[0];
            issue(8'h20 + 8'(l), 8'h00);
            chk({1'b0, isBranch_q, branchTaken_q, instrLength_q, instrCycles_q}, {2'b01, t, 5'h13});
         end
      end
   endtask

   // One-cycle opcodes offered together are decoded on consecutive cycles.
   task automatic back_to_back();
      int hits;
      hits = 0;
      for (int i = 0; i < 4; i++) mem.put(8'h40 + 8'(i), 8'h00);
      repeat (7) begin
         @(posedge mclk);
         #2;
         if (decValid_q === 1'b1) hits++;
      end
      chk(8'(hits), 8'h04);
   endtask

   // Main sequence.
   initial begin
      nrst = 1'b0;
      accIn = 8'h00;
      {irqPin, flagMask, flagHalf, flagNegative, flagZero, flagCarry} = 6'h00;
      repeat (8) @(posedge mclk);
      #2;
      chk({opMode_q, instrLength_q, instrCycles_q}, 8'he9);
      nrst = 1'b1;
      regmem_sweep();
      mem.gap = 2; // Slow memory for the branch sweep.
      branch_sweep();
      mem.gap = 0;
      back_to_back();
      end_sim();
   end

   // Watchdog well beyond the expected run of about 3400 cycles.
   initial begin
      #500000;
      fails++;
      end_sim();
   end
endmodule

`default_nettype wire

// *** bench/prog_memory_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Program memory that offers queued opcode and operand pairs.
module prog_memory_model (
   // Clock and reset.
   input wire logic mclk,
   input wire logic nrst,
   // Handshake with the decoder.
   input wire logic fetchReady,
   output logic fetchValid,
   output logic [7:0] fetchByte,
   output logic [7:0] operandByte
);
   logic [15:0] pend[$]; // Pairs waiting, oldest first.
   int gap = 0; // Idle cycles after each take, to act slowly.
   int idle = 0; // Idle cycles still to wait.
   logic taken; // Pair accepted at this edge.

   // Queue one pair for presentation.
   task automatic put(input logic [7:0] op, input logic [7:0] opd);
      pend.push_back({op, opd});
   endtask

   initial begin
      fetchValid = 1'b0;
      fetchByte = 8'h00;
      operandByte = 8'h00;
   end

   // Retire a taken pair, then show the next one just after the edge.
   // An idle bus carries inverted bytes so nothing stale looks valid.
   always @(posedge mclk) begin
      taken = fetchValid && fetchReady && nrst;
      #2;
      if (taken) begin
         void'(pend.pop_front());
         idle = gap;
      end
      if (pend.size() > 0 && idle == 0) begin
         fetchValid = 1'b1;
         {fetchByte, operandByte} = pend[0];
      end else begin
         if (idle > 0) idle--;
         fetchValid = 1'b0;
         fetchByte = ~fetchByte;
         operandByte = ~operandByte;
      end
   end
endmodule

`default_nettype wire

// *** inc/cpu_opcode_map.vh ***
`ifndef CPU_OPCODE_MAP_VH
`define CPU_OPCODE_MAP_VH

// Addressing modes reported on opMode.
`define MODE_IMM 3'h0
`define MODE_DIR 3'h1
`define MODE_EXT 3'h2
`define MODE_IX 3'h3
`define MODE_IX1 3'h4
`define MODE_IX2 3'h5
`define MODE_REL 3'h6
`define MODE_NONE 3'h7

// Upper opcode nibbles that select a mode.
`define NIB_IMM 4'ha
`define NIB_DIR 4'hb
`define NIB_EXT 4'hc
`define NIB_IX2 4'hd
`define NIB_IX1 4'he
`define NIB_IX 4'hf
`define NIB_BRANCH 4'h2

// Register/memory operations, from the lower opcode nibble.
`define OP_MINUS 4'h0
`define OP_COMPARE_ACCUMULATOR 4'h1
`define OP_MINUS_WITH_BORROW 4'h2
`define OP_COMPARE_INDEX 4'h3
`define OP_AND 4'h4
`define OP_BIT_TEST 4'h5
`define OP_LOAD_ACCUMULATOR 4'h6
`define OP_SAVE_ACCUMULATOR 4'h7
`define OP_XOR_INTO_ACCUMULATOR 4'h8
`define OP_ADD_WITH_CARRY 4'h9
`define OP_OR_INTO_ACCUMULATOR 4'ha
`define OP_ADD 4'hb
`define OP_JUMP_OP 4'hc
`define OP_JUMP_CALL 4'hd
`define OP_LOAD_INDEX 4'he
`define OP_SAVE_INDEX 4'hf

// Instruction lengths in bytes.
`define LEN_IMM 2'h2
`define LEN_DIR 2'h2
`define LEN_EXT 2'h3
`define LEN_IX 2'h1
`define LEN_IX1 2'h2
`define LEN_IX2 2'h3
`define LEN_BRANCH 2'h2
`define LEN_NONE 2'h1

// Execution cycles of loads, arithmetic, logic, compare and bit test.
`define CYC_IMM 3'h2
`define CYC_DIR 3'h3
`define CYC_EXT 3'h4
`define CYC_IX 3'h3
`define CYC_IX1 3'h4
`define CYC_IX2 3'h5

// Adjustments for stores, jumps and subroutine jumps.
`define CYC_SAVE_EXTRA 3'h1
`define CYC_JUMP_LESS 3'h1
`define CYC_CALL_EXTRA 3'h2

// Relative branches and the relative subroutine call.
`define CYC_BRANCH 3'h3
`define OPC_CALL_RELATIVE 8'had
`define CYC_CALL_RELATIVE 3'h6
`define CYC_NONE 3'h1

// Branch condition codes, from the lower nibble of a 2x opcode.
`define BR_ALWAYS 4'h0
`define BR_NEVER 4'h1
`define BR_HIGHER 4'h2
`define BR_LOWER_SAME 4'h3
`define BR_CARRY_CLEAR 4'h4
`define BR_CARRY_SET 4'h5
`define BR_NOT_EQUAL 4'h6
`define BR_EQUAL 4'h7
`define BR_HALFCARRY_CLEAR 4'h8
`define BR_HALFCARRY_SET 4'h9
`define BR_PLUS 4'ha
`define BR_MINUS 4'hb
`define BR_MASK_CLEAR 4'hc
`define BR_MASK_SET 4'hd
`define BR_IRQ_LOW 4'he
`define BR_IRQ_HIGH 4'hf

`endif

// *** rtl/branch_condition_eval.v ***
`timescale 1ns/1ps
`default_nettype none
`include "cpu_opcode_map.vh"

// Pure combinational test of one relative-branch condition.
module branch_condition_eval (
   // Condition selector, the lower nibble of the branch opcode.
   input wire [3:0] condSel,
   // Condition code flags and the interrupt pin level.
   input wire flagCarry,
   input wire flagZero,
   input wire flagNegative,
   input wire flagHalf,
   input wire flagMask,
   input wire irqPin,
   // High when the branch is to be taken.
   output reg takeBranch
);

   // One branch per code; the 24 and 25 encodings double as the unsigned forms.
   always @* begin
      case (condSel)
         `BR_ALWAYS: takeBranch = 1'b1;
         `BR_NEVER: takeBranch = 1'b0;
         `BR_HIGHER: takeBranch = ~(flagCarry | flagZero);
         `BR_LOWER_SAME: takeBranch = flagCarry | flagZero;
         `BR_CARRY_CLEAR: takeBranch = ~flagCarry;
         `BR_CARRY_SET: takeBranch = flagCarry;
         `BR_NOT_EQUAL: takeBranch = ~flagZero;
         `BR_EQUAL: takeBranch = flagZero;
         `BR_HALFCARRY_CLEAR: takeBranch = ~flagHalf;
         `BR_HALFCARRY_SET: takeBranch = flagHalf;
         `BR_PLUS: takeBranch = ~flagNegative;
         `BR_MINUS: takeBranch = flagNegative;
         `BR_MASK_CLEAR: takeBranch = ~flagMask;
         `BR_MASK_SET: takeBranch = flagMask;
         `BR_IRQ_LOW: takeBranch = ~irqPin;
         `BR_IRQ_HIGH: takeBranch = irqPin;
         default: takeBranch = 1'b0;
      endcase
   end

endmodule

`default_nettype wire

// *** rtl/cpu_opcode_decode_timing.v ***
`timescale 1ns/1ps
`default_nettype none
`include "cpu_opcode_map.vh"

module cpu_opcode_decode_timing (
   // Clock and reset.
   input wire mclk,
   input wire nrst,
   // Instruction byte from program memory, with its first operand byte.
   input wire fetchValid,
   input wire [7:0] fetchByte,
   input wire [7:0] operandByte,
   output wire fetchReady,
   // Core state that the decoder reads.
   input wire [7:0] accIn,
   input wire flagCarry,
   input wire flagZero,
   input wire flagNegative,
   input wire flagHalf,
   input wire flagMask,
   input wire irqPin,
   // Decoded instruction.
   output reg decValid_q,
   output reg [2:0] opMode_q,
   output reg [3:0] aluOp_q,
   output reg [1:0] instrLength_q,
   output reg [2:0] instrCycles_q,
   output reg isRegMem_q,
   output reg isBranch_q,
   output reg branchTaken_q,
   output reg pushReturn_q,
   output reg illegalOp_q,
   // Accumulator write-back for loads and logical operations.
   output reg accWrite_q,
   output reg [7:0] accResult_q
);

   // One-hot states of the sequencer.
   localparam [1:0] ST_IDLE = 2'h1;
   localparam [1:0] ST_EXEC = 2'h2;

   // Maps an upper nibble to its addressing mode.
   function [2:0] mode_of;
      input [3:0] hiNib;
      begin
         case (hiNib)
            `NIB_IMM: mode_of = `MODE_IMM;
            `NIB_DIR: mode_of = `MODE_DIR;
            `NIB_EXT: mode_of = `MODE_EXT;
            `NIB_IX: mode_of = `MODE_IX;
            `NIB_IX1: mode_of = `MODE_IX1;
            `NIB_IX2: mode_of = `MODE_IX2;
            `NIB_BRANCH: mode_of = `MODE_REL;
            default: mode_of = `MODE_NONE;
         endcase
      end
   endfunction

   // Byte length of an instruction in a given mode.
   function [1:0] length_of;
      input [2:0] mode;
      begin
         case (mode)
            `MODE_IMM: length_of = `LEN_IMM;
            `MODE_DIR: length_of = `LEN_DIR;
            `MODE_EXT: length_of = `LEN_EXT;
            `MODE_IX: length_of = `LEN_IX;
            `MODE_IX1: length_of = `LEN_IX1;
            `MODE_IX2: length_of = `LEN_IX2;
            `MODE_REL: length_of = `LEN_BRANCH;
            default: length_of = `LEN_NONE;
         endcase
      end
   endfunction

   // Base cycle count of the load/arithmetic class in a given mode.
   function [2:0] base_cycles;
      input [2:0] mode;
      begin
         case (mode)
            `MODE_IMM: base_cycles = `CYC_IMM;
            `MODE_DIR: base_cycles = `CYC_DIR;
            `MODE_EXT: base_cycles = `CYC_EXT;
            `MODE_IX: base_cycles = `CYC_IX;
            `MODE_IX1: base_cycles = `CYC_IX1;
            `MODE_IX2: base_cycles = `CYC_IX2;
            default: base_cycles = `CYC_NONE;
         endcase
      end
   endfunction

   // Sequencer state and the count of busy cycles still to run.
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [2:0] busyCnt_q;
   reg [2:0] busyCnt_d;

   // Combinational decode of the byte on fetchByte.
   reg [2:0] decMode;
   reg [3:0] decOp;
   reg [1:0] decLen;
   reg [2:0] decCycles;
   reg decRegMem;
   reg decBranch;
   reg decPush;
   reg decIllegal;
   reg decAccWrite;
   reg [7:0] decAccResult;

   // Branch condition result for the current opcode.
   wire condTrue;

   // An opcode is taken on a cycle where fetchValid meets fetchReady.
   wire takeOp;

   // The decoder only accepts a new opcode once the last one has run out.
   assign fetchReady = state_q[0];
   assign takeOp = fetchValid & fetchReady;

   // Condition evaluation lives in its own module to keep the table readable.
   branch_condition_eval condEval (
      .condSel(fetchByte[3:0]),
      .flagCarry(flagCarry),
      .flagZero(flagZero),
      .flagNegative(flagNegative),
      .flagHalf(flagHalf),
      .flagMask(flagMask),
      .irqPin(irqPin),
      .takeBranch(condTrue)
   );

   // Main decode: mode, operation, length, cycle count and write-back.
   always @* begin
      decMode = mode_of(fetchByte[7:4]);
      decOp = fetchByte[3:0];
      decLen = length_of(decMode);
      decCycles = `CYC_NONE;
      decRegMem = 1'b0;
      decBranch = 1'b0;
      decPush = 1'b0;
      decIllegal = 1'b0;
      decAccWrite = 1'b0;
      decAccResult = accIn;
      if (fetchByte == `OPC_CALL_RELATIVE) begin
         // The immediate slot of the call column is the relative call.
         decMode = `MODE_REL;
         decLen = `LEN_BRANCH;
         decCycles = `CYC_CALL_RELATIVE;
         decBranch = 1'b1;
         decPush = 1'b1;
      end else if (decMode == `MODE_REL) begin
         // Every relative branch has the same length and timing.
         decCycles = `CYC_BRANCH;
         decBranch = 1'b1;
      end else if (decMode == `MODE_NONE) begin
         // Opcodes of other groups are flagged and pass in one cycle.
         decIllegal = 1'b1;
         decLen = `LEN_NONE;
      end else begin
         decRegMem = 1'b1;
         decCycles = base_cycles(decMode);
         case (decOp)
            `OP_SAVE_ACCUMULATOR, `OP_SAVE_INDEX: begin
               // Stores write memory, so they cost one extra cycle.
               decCycles = base_cycles(decMode) + `CYC_SAVE_EXTRA;
            end
            `OP_JUMP_OP: begin
               // A jump only forms an address, one cycle less than a load.
               decCycles = base_cycles(decMode) - `CYC_JUMP_LESS;
            end
            `OP_JUMP_CALL: begin
               // A subroutine jump also pushes the return address.
               decCycles = base_cycles(decMode) + `CYC_CALL_EXTRA;
               decPush = 1'b1;
            end
            `OP_AND: begin
               decAccWrite = 1'b1;
               decAccResult = accIn & operandByte;
            end
            `OP_XOR_INTO_ACCUMULATOR: begin
               decAccWrite = 1'b1;
               decAccResult = accIn ^ operandByte;
            end
            `OP_OR_INTO_ACCUMULATOR: begin
               decAccWrite = 1'b1;
               decAccResult = accIn | operandByte;
            end
            `OP_LOAD_ACCUMULATOR: begin
               decAccWrite = 1'b1;
               decAccResult = operandByte;
            end
            default: begin
               // Arithmetic, compare and bit test keep the base count.
               decAccWrite = 1'b0;
            end
         endcase
         // Stores and jumps have no immediate form.
         if ((decMode == `MODE_IMM) &&
             ((decOp == `OP_SAVE_ACCUMULATOR) || (decOp == `OP_SAVE_INDEX) ||
              (decOp == `OP_JUMP_OP) || (decOp == `OP_JUMP_CALL))) begin
            decIllegal = 1'b1;
            decRegMem = 1'b0;
            decPush = 1'b0;
            decAccWrite = 1'b0;
            decAccResult = accIn;
            decCycles = `CYC_NONE;
            decLen = `LEN_NONE;
         end
      end
   end

   // Next state: hold off new opcodes until the cycle count has run.
   always @* begin
      state_d = state_q;
      busyCnt_d = busyCnt_q;
      case (state_q)
         ST_IDLE: begin
            // The taking cycle is the first of the instruction's cycles.
            if (takeOp && (decCycles > `CYC_NONE)) begin
               busyCnt_d = decCycles - `CYC_NONE;
               state_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            // Count down the remaining cycles, then accept again.
            busyCnt_d = busyCnt_q - 3'h1;
            if (busyCnt_q == 3'h1) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            // Recover from any illegal state code.
            state_d = ST_IDLE;
            busyCnt_d = 3'h0;
         end
      endcase
   end

   // Sequencer registers.
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         busyCnt_q <= 3'h0;
      end else begin
         state_q <= state_d;
         busyCnt_q <= busyCnt_d;
      end
   end

   // Decoded fields are latched when an opcode is taken and held after.
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         opMode_q <= `MODE_NONE;
         aluOp_q <= 4'h0;
         instrLength_q <= `LEN_NONE;
         instrCycles_q <= `CYC_NONE;
         isRegMem_q <= 1'b0;
         isBranch_q <= 1'b0;
         branchTaken_q <= 1'b0;
         pushReturn_q <= 1'b0;
         illegalOp_q <= 1'b0;
         accResult_q <= 8'h00;
      end else if (takeOp) begin
         opMode_q <= decMode;
         aluOp_q <= decOp;
         instrLength_q <= decLen;
         instrCycles_q <= decCycles;
         isRegMem_q <= decRegMem;
         isBranch_q <= decBranch;
         // The relative call always branches; 2x opcodes test their flag.
         branchTaken_q <= decPush ? decBranch : (decBranch & condTrue);
         pushReturn_q <= decPush;
         illegalOp_q <= decIllegal;
         accResult_q <= decAccResult;
      end
   end

   // Pulses are one cycle wide so a consumer never acts twice on one opcode.
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         decValid_q <= 1'b0;
         accWrite_q <= 1'b0;
      end else begin
         decValid_q <= takeOp;
         accWrite_q <= takeOp & decAccWrite;
      end
   end

endmodule

`default_nettype wire
